//--- hw/acs_sync_source_selector.sv
`timescale 1ns/1ps
`include "acs_params.svh"

// Overview of operation
// - auto mode follows matching valid input as slave
// - master mode runs internal clock, ignores inputs
// - candidates: word clock, adat optical, sync, spdif
// - preferred valid input wins, else scan in turn
// - first valid input adopted; inputs received together
// - no valid candidate falls back to master
// - per input: no signal, lock or sync
// - report active reference and its frequency
// - report system clock master or slave
// - word clock follows rate, optionally halved at double speed
// - accept rates 28 to 103 kHz
// - double speed uses sample multiplexing on adat
// - spdif receiver input coaxial or optical
// - spdif out always coaxial, optionally optical
// - expansion setting selects first adat input
// - spdif input rate readable separately
module acs_sync_source_selector #(
  parameter int P_PER_MAX = `ACS_PER_MAX
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic [5:0]  i_src_clk,
  input  wire logic        i_spdif_coax,
  input  wire logic        i_opt1_in,
  input  wire logic        i_adat1_opt,
  input  wire logic        i_internal_connector_input,
  input  wire logic        i_spdif_tx,
  input  wire logic        i_adat1_tx,
  output logic             o_spdif_rx_in,
  output logic             o_adat1_rx_in,
  output logic             o_spdif_coax,
  output logic             o_opt1_out,
  output logic             o_sample_clk,
  output logic             o_word_clk,
  output logic             o_slave,
  output logic             o_smux,
  output logic             o_irq
);

  localparam int NS = `ACS_NSRC;

  // ==========================================================
  // declarations
  logic [9:0]               sync1_ff;
  logic [9:0]               sync2_ff;
  logic [5:0]               src_d_ff;
  logic [5:0]               src_lvl;
  acs_pkg::acs_per_t        cnt_ff [NS];
  acs_pkg::acs_per_t        per_ff [NS];
  logic [NS-1:0]            valid_ff;
  logic [NS-1:0]            valid_d_ff;
  logic [NS-1:0]            elig;
  acs_pkg::acs_lock_e       lock_st [NS];
  logic [7:0]               ctrl_ff;
  acs_pkg::acs_per_t        rate_ff;
  acs_pkg::acs_per_t        sys_per;
  acs_pkg::acs_per_t        int_cnt_ff;
  logic                     int_clk_ff;
  logic                     smux;
  logic                     want_slave;
  logic [2:0]               want_sel;
  logic                     slave_ff;
  logic [2:0]               sel_ff;
  logic                     new_lvl;
  logic                     cur_lvl;
  logic                     do_switch;
  logic                     sclk_ff;
  logic                     sclk_d_ff;
  logic                     div_ff;
  logic                     wc_ff;
  logic                     wc_half;
  logic                     spdif_rx_ff;
  logic                     adat1_rx_ff;
  logic                     coax_ff;
  logic                     opt1_ff;
  logic [`ACS_IRQ_W-1:0]    irq_stat_ff;
  logic [`ACS_IRQ_W-1:0]    irq_mask_ff;
  logic [`ACS_IRQ_W-1:0]    irq_ev;
  logic [31:0]              prdata_ff;
  logic                     apb_wr;
  logic [2:0]               pref;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  // ==========================================================
  // helpers
  function automatic logic is_adat(input logic [2:0] idx);
    return (idx >= `ACS_SRC_ADAT1) && (idx <= `ACS_SRC_ADAT3);
  endfunction : is_adat

  // adat frames run at half rate while multiplexing
  function automatic acs_pkg::acs_per_t exp_per(
    input logic [2:0]        idx,
    input acs_pkg::acs_per_t base,
    input logic              mux
  );
    return (is_adat(idx) && mux) ? {base[12:0], 1'b0} : base;
  endfunction : exp_per

  function automatic logic per_match(
    input acs_pkg::acs_per_t a,
    input acs_pkg::acs_per_t b
  );
    return ((a > b) ? (a - b) : (b - a)) <= `ACS_PER_TOL;
  endfunction : per_match

  function automatic logic [2:0] wrap6(input logic [3:0] v);
    return (v >= 4'(NS)) ? 3'(v - 4'(NS)) : v[2:0];
  endfunction : wrap6

  function automatic logic mapped(input logic [7:0] a);
    return (a == `ACS_REG_CTRL)    || (a == `ACS_REG_RATE)    ||
           (a == `ACS_REG_STATUS)  || (a == `ACS_REG_REFFREQ) ||
           (a == `ACS_REG_SPDFREQ) || (a == `ACS_REG_IRQSTAT) ||
           (a == `ACS_REG_IRQMASK);
  endfunction : mapped

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      src_d_ff <= '0;
    end else begin
      sync1_ff <= {i_internal_connector_input, i_adat1_opt, i_opt1_in, i_spdif_coax, i_src_clk};
      sync2_ff <= sync1_ff;
      src_d_ff <= sync2_ff[5:0];
    end
  end

  assign src_lvl = sync2_ff[5:0];

  // ==========================================================
  // per-input rate measurement and lock state
  // all six inputs are measured in parallel, so a switch needs no new measurement
  for (genvar i = 0; i < NS; i++) begin : g_src
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        cnt_ff[i]   <= '0;
        per_ff[i]   <= '0;
        valid_ff[i] <= 1'b0;
      end else if (src_lvl[i] && !src_d_ff[i]) begin
        cnt_ff[i]   <= 14'h0001;
        per_ff[i]   <= cnt_ff[i];
        valid_ff[i] <= (cnt_ff[i] >= 14'(`ACS_PER_MIN)) &&
                       (cnt_ff[i] <= 14'(P_PER_MAX)) &&
                       per_match(cnt_ff[i], per_ff[i]);
      end else if (cnt_ff[i] > 14'(P_PER_MAX)) begin
        // input stalled: drop lock without waiting for an edge
        valid_ff[i] <= 1'b0;
      end else begin
        cnt_ff[i] <= cnt_ff[i] + 14'h0001;
      end
    end

    always_comb begin
      elig[i] = valid_ff[i] &&
                per_match(per_ff[i], exp_per(3'(i), rate_ff, smux));
      if (!valid_ff[i]) begin
        lock_st[i] = acs_pkg::ACS_NO_SIG;
      end else if (per_match(per_ff[i], exp_per(3'(i), sys_per, smux))) begin
        lock_st[i] = acs_pkg::ACS_SYNC;
      end else begin
        lock_st[i] = acs_pkg::ACS_LOCK;
      end
    end
  end

  a_sync_needs_lock: assert property (
    (lock_st[5] != acs_pkg::ACS_NO_SIG) |-> valid_ff[5])
    else $error("lock state shown without valid signal");

  a_valid_in_range: assert property (
    $rose(valid_ff[0]) |-> (per_ff[0] >= 14'(`ACS_PER_MIN)) &&
                           (per_ff[0] <= 14'(P_PER_MAX)))
    else $error("word clock valid outside rate range");

  // ==========================================================
  // internal oscillator
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_cnt_ff <= '0;
      int_clk_ff <= 1'b0;
    end else begin
      if (int_cnt_ff >= rate_ff - 14'h0001) begin
        int_cnt_ff <= '0;
      end else begin
        int_cnt_ff <= int_cnt_ff + 14'h0001;
      end
      int_clk_ff <= (int_cnt_ff < {1'b0, rate_ff[13:1]});
    end
  end

  assign smux    = (rate_ff < 14'(`ACS_DS_PER));
  assign sys_per = !slave_ff ? rate_ff :
                   (is_adat(sel_ff) && smux) ? {1'b0, per_ff[sel_ff][13:1]} :
                   per_ff[sel_ff];

  // ==========================================================
  // reference selection
  assign pref = ctrl_ff[`ACS_CTRL_PREF_HI:`ACS_CTRL_PREF_LO];

  always_comb begin
    logic [2:0] idx;
    idx        = pref;
    want_slave = 1'b0;
    want_sel   = sel_ff;
    // scan starts at the preferred input and wraps round
    for (int k = 0; k < NS; k++) begin
      idx = wrap6({1'b0, pref} + 4'(k));
      if (!want_slave && elig[idx]) begin
        want_slave = 1'b1;
        want_sel   = idx;
      end
    end
    if (!ctrl_ff[`ACS_CTRL_AUTO]) begin
      want_slave = 1'b0;
      want_sel   = sel_ff;
    end
  end

  a_master_ignores: assert property (
    !ctrl_ff[`ACS_CTRL_AUTO] |-> !want_slave && (want_sel == sel_ff))
    else $error("master mode selected an input");

  a_fallback_master: assert property (
    (elig == '0) |-> !want_slave)
    else $error("no candidate but slave requested");

  a_pref_wins: assert property (
    ctrl_ff[`ACS_CTRL_AUTO] && elig[pref] |-> want_slave && (want_sel == pref))
    else $error("preferred valid input not chosen");

  a_choice_valid: assert property (
    want_slave |-> elig[want_sel] && ctrl_ff[`ACS_CTRL_AUTO])
    else $error("selected input is not valid");

  // ==========================================================
  // glitch-free clock switch
  // the change is taken only while both the sample clock output and the new clock are low,
  // so the output never shows a shortened high phase
  assign new_lvl   = want_slave ? src_lvl[want_sel] : int_clk_ff;
  assign cur_lvl   = slave_ff ? src_lvl[sel_ff] : int_clk_ff;
  assign do_switch = ((want_slave != slave_ff) || (want_sel != sel_ff)) &&
                     !sclk_ff && !new_lvl;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      slave_ff <= 1'b0;
      sel_ff   <= `ACS_SRC_WC;
      sclk_ff  <= 1'b0;
    end else if (do_switch) begin
      slave_ff <= want_slave;
      sel_ff   <= want_sel;
      sclk_ff  <= 1'b0;
    end else begin
      sclk_ff  <= cur_lvl;
    end
  end

  a_no_runt: assert property (
    ($changed(slave_ff) || $changed(sel_ff)) |-> !$past(sclk_ff) && !sclk_ff)
    else $error("clock switched while sample clock high");

  a_ref_report: assert property (
    i_psel && !i_penable && (i_paddr == `ACS_REG_REFFREQ) |=>
      (prdata_ff[13:0] == $past(per_ff[sel_ff])))
    else $error("reference rate read back wrong");

  // ==========================================================
  // word clock output
  assign wc_half = ctrl_ff[`ACS_CTRL_WCHALF] && smux;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_d_ff <= 1'b0;
      div_ff    <= 1'b0;
      wc_ff     <= 1'b0;
    end else begin
      sclk_d_ff <= sclk_ff;
      if (sclk_ff && !sclk_d_ff) begin
        div_ff <= !div_ff;
      end
      wc_ff <= wc_half ? div_ff : sclk_ff;
    end
  end

  a_wc_follow: assert property (
    !wc_half && $past(!wc_half) |-> (wc_ff == $past(sclk_ff)))
    else $error("word clock does not follow sample clock");

  a_wc_halved: assert property (
    wc_half ##1 wc_half |-> (wc_ff == $past(div_ff)))
    else $error("word clock not halved in double speed");

  // ==========================================================
  // signal routing
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      spdif_rx_ff <= 1'b0;
      adat1_rx_ff <= 1'b0;
      coax_ff     <= 1'b0;
      opt1_ff     <= 1'b0;
    end else begin
      spdif_rx_ff <= ctrl_ff[`ACS_CTRL_SPDIN] ? sync2_ff[7] : sync2_ff[6];
      adat1_rx_ff <= ctrl_ff[`ACS_CTRL_EXPIN] ? sync2_ff[9] : sync2_ff[8];
      coax_ff     <= i_spdif_tx;
      opt1_ff     <= ctrl_ff[`ACS_CTRL_SPDOUT] ? i_spdif_tx : i_adat1_tx;
    end
  end

  a_spdif_route: assert property (
    ctrl_ff[`ACS_CTRL_SPDIN] |=> (spdif_rx_ff == $past(sync2_ff[7])))
    else $error("spdif receiver not fed from optical input");

  a_opt_route: assert property (
    ctrl_ff[`ACS_CTRL_SPDOUT] |=> (opt1_ff == $past(i_spdif_tx)) &&
                                  (coax_ff == $past(i_spdif_tx)))
    else $error("spdif output not mirrored to optical");

  a_exp_route: assert property (
    ctrl_ff[`ACS_CTRL_EXPIN] |=> (adat1_rx_ff == $past(sync2_ff[9])))
    else $error("first adat input not taken from connector");

  // ==========================================================
  // interrupt events
  assign irq_ev[`ACS_IRQ_MODE] = do_switch && (want_slave != slave_ff);
  assign irq_ev[`ACS_IRQ_REF]  = do_switch && (want_sel != sel_ff);
  assign irq_ev[`ACS_IRQ_LOST] = |(valid_d_ff & ~valid_ff);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      valid_d_ff  <= '0;
      irq_stat_ff <= '0;
    end else begin
      valid_d_ff <= valid_ff;
      // a new event wins over a simultaneous clear
      if (apb_wr && (i_paddr == `ACS_REG_IRQSTAT)) begin
        irq_stat_ff <= (irq_stat_ff & ~i_pwdata[`ACS_IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_stat_ff <= irq_stat_ff | irq_ev;
      end
    end
  end

  // ==========================================================
  // apb slave: zero wait states, read data latched in setup phase
  assign apb_wr = i_psel && i_penable && i_pwrite;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_ff     <= `ACS_CTRL_RST;
      rate_ff     <= 14'(`ACS_RATE_RST);
      irq_mask_ff <= '0;
    end else if (apb_wr) begin
      unique case (i_paddr)
        `ACS_REG_CTRL: begin
          ctrl_ff <= i_pwdata[7:0];
          // out-of-range preference keeps the old choice
          if (i_pwdata[`ACS_CTRL_PREF_HI:`ACS_CTRL_PREF_LO] > `ACS_SRC_SPDIF) begin
            ctrl_ff[`ACS_CTRL_PREF_HI:`ACS_CTRL_PREF_LO] <= pref;
          end
        end
        `ACS_REG_RATE: begin
          if (i_pwdata[13:0] >= 14'h0002) begin
            rate_ff <= i_pwdata[13:0];
          end
        end
        `ACS_REG_IRQMASK: irq_mask_ff <= i_pwdata[`ACS_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prdata_ff <= '0;
    end else if (i_psel && !i_penable) begin
      prdata_ff <= '0;
      unique case (i_paddr)
        `ACS_REG_CTRL:    prdata_ff[7:0]  <= ctrl_ff;
        `ACS_REG_RATE:    prdata_ff[13:0] <= rate_ff;
        `ACS_REG_STATUS: begin
          for (int i = 0; i < NS; i++) begin
            prdata_ff[2*i +: 2] <= lock_st[i];
          end
          prdata_ff[`ACS_ST_SLAVE]                   <= slave_ff;
          prdata_ff[`ACS_ST_REF_HI:`ACS_ST_REF_LO]   <= sel_ff;
          prdata_ff[`ACS_ST_SMUX]                    <= smux;
        end
        `ACS_REG_REFFREQ: prdata_ff[13:0] <= per_ff[sel_ff];
        `ACS_REG_SPDFREQ: prdata_ff[13:0] <= per_ff[5];
        `ACS_REG_IRQSTAT: prdata_ff[`ACS_IRQ_W-1:0] <= irq_stat_ff;
        `ACS_REG_IRQMASK: prdata_ff[`ACS_IRQ_W-1:0] <= irq_mask_ff;
        default: ;
      endcase
    end
  end

  a_spdif_freq: assert property (
    i_psel && !i_penable && (i_paddr == `ACS_REG_SPDFREQ) |=>
      (prdata_ff[13:0] == $past(per_ff[5])))
    else $error("spdif rate read back wrong");

  // ==========================================================
  // outputs
  assign o_prdata      = prdata_ff;
  assign o_pready      = 1'b1;
  assign o_pslverr     = i_psel && i_penable && !mapped(i_paddr);
  assign o_spdif_rx_in = spdif_rx_ff;
  assign o_adat1_rx_in = adat1_rx_ff;
  assign o_spdif_coax  = coax_ff;
  assign o_opt1_out    = opt1_ff;
  assign o_sample_clk  = sclk_ff;
  assign o_word_clk    = wc_ff;
  assign o_slave       = slave_ff;
  assign o_smux        = smux;
  assign o_irq         = |(irq_stat_ff & irq_mask_ff);

  a_smux_speed: assert property (
    (rate_ff < 14'(`ACS_DS_PER)) |-> o_smux)
    else $error("double speed without sample multiplexing");

endmodule : acs_sync_source_selector

//--- hw/acs_params.svh
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// core clock and accepted recovery range
`define ACS_CORE_HZ      200000000
`define ACS_MIN_RATE_HZ  28000
`define ACS_MAX_RATE_HZ  103000
`define ACS_DEF_RATE_HZ  48000
`define ACS_DS_RATE_HZ   56000
`define ACS_PER_MAX      (`ACS_CORE_HZ / `ACS_MIN_RATE_HZ)
`define ACS_PER_MIN      ((`ACS_CORE_HZ + `ACS_MAX_RATE_HZ - 1) / `ACS_MAX_RATE_HZ)
`define ACS_RATE_RST     (`ACS_CORE_HZ / `ACS_DEF_RATE_HZ)
`define ACS_DS_PER       (`ACS_CORE_HZ / `ACS_DS_RATE_HZ)
`define ACS_PER_TOL      14'h0010
`define ACS_PER_W        14

// source indices
`define ACS_NSRC         6
`define ACS_SRC_WC       3'h0
`define ACS_SRC_ADAT1    3'h1
`define ACS_SRC_ADAT3    3'h3
`define ACS_SRC_ASYNC    3'h4
`define ACS_SRC_SPDIF    3'h5

// register byte offsets
`define ACS_REG_CTRL     8'h00
`define ACS_REG_RATE     8'h04
`define ACS_REG_STATUS   8'h08
`define ACS_REG_REFFREQ  8'h0C
`define ACS_REG_SPDFREQ  8'h10
`define ACS_REG_IRQSTAT  8'h14
`define ACS_REG_IRQMASK  8'h18

// control fields
`define ACS_CTRL_AUTO    0
`define ACS_CTRL_PREF_LO 1
`define ACS_CTRL_PREF_HI 3
`define ACS_CTRL_SPDIN   4
`define ACS_CTRL_SPDOUT  5
`define ACS_CTRL_EXPIN   6
`define ACS_CTRL_WCHALF  7
`define ACS_CTRL_RST     8'h00

// status fields
`define ACS_ST_SLAVE     12
`define ACS_ST_REF_LO    13
`define ACS_ST_REF_HI    15
`define ACS_ST_SMUX      16

// interrupt events
`define ACS_IRQ_W        3
`define ACS_IRQ_MODE     0
`define ACS_IRQ_REF      1
`define ACS_IRQ_LOST     2

`endif

//--- hw/acs_pkg.sv
package acs_pkg;

  typedef enum logic [1:0] {
    ACS_NO_SIG,
    ACS_LOCK,
    ACS_SYNC
  } acs_lock_e;

  typedef logic [13:0] acs_per_t;

endpackage : acs_pkg

//--- sim/acs_src_model.sv
`timescale 1ns/1ps
// ==========================================
// far-side recovered clocks, one per source
// ==========================================
module acs_src_model #(
  parameter int P_PER [6] = '{4166, 4535, 4166, 4166, 1800, 4166}
) (
  input  wire logic [5:0] i_en,
  output logic      [5:0] o_clk
);
  for (genvar k = 0; k < 6; k++) begin : g_src
    logic c;
    assign o_clk[k] = c;
    // staggered start keeps equal-rate sources out of phase; a stopped source idles low
    initial begin
      c = 1'b0;
      #(k * 1300.7);
      forever begin
        if (i_en[k]) begin
          c = 1'b1;
          #(P_PER[k] * 2.5);
          c = 1'b0;
          #(P_PER[k] * 2.5);
        end else begin
          @(i_en);
        end
      end
    end
  end
endmodule : acs_src_model

//--- sim/tb_top.sv
`timescale 1ns/1ps
`include "acs_params.svh"
module tb_top;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [5:0]  src_en, src_clk;
  logic        sp_coax, opt1_in, ad_opt, ad_int, sp_tx, ad_tx;
  logic        sp_rx, ad_rx, sp_out, opt1_out, smp_clk, wc, slave, smux, irq;
  logic [32:0] exp_q[$];
  logic [31:0] msk_q[$];
  int          mismatches, tests_run, cyc;

  acs_sync_source_selector dut_u (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_src_clk(src_clk),
    .i_spdif_coax(sp_coax), .i_opt1_in(opt1_in), .i_adat1_opt(ad_opt),
    .i_internal_connector_input(ad_int), .i_spdif_tx(sp_tx), .i_adat1_tx(ad_tx),
    .o_spdif_rx_in(sp_rx), .o_adat1_rx_in(ad_rx), .o_spdif_coax(sp_out),
    .o_opt1_out(opt1_out), .o_sample_clk(smp_clk), .o_word_clk(wc),
    .o_slave(slave), .o_smux(smux), .o_irq(irq)
  );
  acs_src_model src_u (.i_en(src_en), .o_clk(src_clk));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================
  // helpers
  // ==========================================
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic note(input logic ok, input logic [32:0] g, input logic [32:0] e);
    tests_run++;
    if (!ok) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : note

  task automatic chk_rd(input logic [32:0] g, input logic [32:0] e);
    note(g === e, g, e);
  endtask : chk_rd

  task automatic chk_pin(input logic g, input logic e);
    note(g === e, {32'h0000_0000, g}, {32'h0000_0000, e});
  endtask : chk_pin

  task automatic chk_per(input int g, input int e);
    note(g <= e + 1 && g >= e - 1, 33'(g), 33'(e));
  endtask : chk_per

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic er);
    exp_q.push_back({er, e & m});
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  // word clock edges are sampled mid-cycle, away from the launching edge
  task automatic wc_rise();
    logic p;
    p = wc;
    repeat (10000) begin
      @(negedge clk);
      if (wc === 1'b1 && p === 1'b0) break;
      p = wc;
    end
  endtask : wc_rise

  task automatic wc_per(input int e);
    realtime t0;
    wc_rise();
    t0 = $realtime;
    wc_rise();
    chk_per(int'(($realtime - t0) / 5.0), e);
  endtask : wc_per

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  // ==========================================
  // read result watcher and hang guard
  // ==========================================
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      chk_rd({pslverr, prdata & msk_q.pop_front()}, exp_q.pop_front());
    end
  end

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 100000) begin
      mismatches++;
      end_of_test();
    end
  end

  // ==========================================
  // main sequence
  // ==========================================
  initial begin
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    src_en  = 6'h33;
    {sp_coax, opt1_in, ad_opt, ad_int, sp_tx, ad_tx} = 6'h00;
    seed    = 32'h0001_3DB0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(`ACS_REG_CTRL, 32'h0000_0000, 32'h0000_00FF, 1'b0);
    rd(`ACS_REG_RATE, 32'h0000_1046, 32'h0000_3FFF, 1'b0);
    rd(`ACS_REG_IRQMASK, 32'h0000_0000, 32'h0000_0007, 1'b0);
    rd(8'h1C, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      apb(1'b1, `ACS_REG_CTRL, {24'h00_0000, 1'b0, i[2:0], 4'h0});
      {ad_tx, sp_tx, ad_int, ad_opt, opt1_in, sp_coax} <= seed[5:0];
      settle(6);
      chk_pin(sp_rx, i[0] ? seed[1] : seed[0]);
      chk_pin(opt1_out, i[1] ? seed[4] : seed[5]);
      chk_pin(sp_out, seed[4]);
      chk_pin(ad_rx, i[2] ? seed[3] : seed[2]);
    end
    $display("test routing done");
    apb(1'b1, `ACS_REG_CTRL, 32'h0000_0000);
    apb(1'b1, `ACS_REG_IRQMASK, 32'h0000_0007);
    settle(17000);
    chk_pin(slave, 1'b0);
    rd(`ACS_REG_STATUS, 32'h0000_0806, 32'h0001_FFFF, 1'b0);
    rd(`ACS_REG_SPDFREQ, 32'h0000_1046, 32'h0000_3FFF, 1'b0);
    $display("test master done");
    // every preferred code; unmatched or dead picks fall through to the spdif source
    for (int p = 0; p < 6; p++) begin
      apb(1'b1, `ACS_REG_CTRL, {28'h000_0000, p[2:0], 1'b1});
      settle(5000);
      chk_pin(slave, 1'b1);
      rd(`ACS_REG_STATUS, {16'h0000, (p == 0) ? 3'h0 : 3'h5, 13'h1806},
         32'h0001_FFFF, 1'b0);
    end
    chk_pin(smux, 1'b0);
    rd(`ACS_REG_REFFREQ, 32'h0000_1046, 32'h0000_3FFF, 1'b0);
    rd(`ACS_REG_IRQSTAT, 32'h0000_0003, 32'h0000_0003, 1'b0);
    chk_pin(irq, 1'b1);
    apb(1'b1, `ACS_REG_IRQSTAT, 32'h0000_0007);
    settle(2);
    chk_pin(irq, 1'b0);
    rd(`ACS_REG_IRQSTAT, 32'h0000_0000, 32'h0000_0007, 1'b0);
    $display("test auto done");
    src_en <= 6'h00;
    // stall detection, then a low phase of the internal clock before the switch
    settle(10500);
    chk_pin(slave, 1'b0);
    rd(`ACS_REG_STATUS, 32'h0000_0000, 32'h0000_1FFF, 1'b0);
    rd(`ACS_REG_IRQSTAT, 32'h0000_0005, 32'h0000_0005, 1'b0);
    chk_pin(irq, 1'b1);
    $display("test fallback done");
    apb(1'b1, `ACS_REG_RATE, 32'h0000_0823);
    apb(1'b1, `ACS_REG_RATE, 32'h0000_0001);
    rd(`ACS_REG_RATE, 32'h0000_0823, 32'h0000_3FFF, 1'b0);
    settle(2);
    chk_pin(smux, 1'b1);
    wc_rise();
    chk_pin(smp_clk, 1'b1);
    wc_per(2083);
    apb(1'b1, `ACS_REG_CTRL, 32'h0000_0080);
    wc_rise();
    wc_per(4166);
    $display("test word clock done");
    end_of_test();
  end
endmodule : tb_top
